// ### design/idc_top.sv
// Behaviour
// - 31-segment bargraph, settable start and finish.
// - Justify left, centre, right, alarm, off.
// - Start and finish edited digit by digit.
// - Start not below finish flashes one segment.
// - P key shows milliamps or percent span.
// - E held over 3 s zeroes display.
// - Bargraph follows the tared value.
// - Short E press restores gross reading.
// - Menu entry needs matching four-digit code.
// - Default code gives unrestricted entry.
// - New code active on return to display.
// - Restore indicator or lineariser defaults separately.
// - Restore only after confirm word and restore bit.
// - Out of range shows nines, flashing points.
// - Below 1.8 mA show loop-low message.
// - Outside bar span lights end arrow.
// - Lineariser has seventeen break-points, 0 to 16.
// - Bad break-point current fails, is discarded.
// - Lineariser leaves menu, extends calibrations.
// - Lineariser table kept when function changes.
// - Percent computed against 4 mA and 20 mA.
`timescale 1ns/10ps
`default_nettype none
module idc_top
#(
  parameter int TARE_CYCLES = idc_pkg::IDC_TARE_CYCLES,
  parameter int BP_NUM      = idc_pkg::IDC_BP_NUM
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Operator keys and measured loop current in microamps.
  input  wire logic        key_p,
  input  wire logic        key_e,
  input  wire logic        menu_request,
  input  wire logic [15:0] loop_current,
  input  wire logic [15:0] entered_code,
  // Display.
  output var  logic [17:0] disp_value,
  output var  logic        disp_mode_ma,
  output var  logic        disp_mode_pct,
  output var  logic        dp_flash,
  output var  logic        loop_low_message,
  output var  logic        fail_message,
  output var  logic        tare_annunciator,
  output var  logic [30:0] bar_segments,
  output var  logic        bar_flash,
  output var  logic        arrow_low,
  output var  logic        arrow_high,
  output var  logic        menu_granted
);
  import idc_pkg::*;
  localparam int TW = $clog2(TARE_CYCLES + 1);
  function automatic logic signed [31:0] clamp_pct(input logic signed [31:0] num,
                                                   input logic signed [31:0] den);
    clamp_pct = (den == 0) ? 32'sd0 : (num * 32'sd1000) / den;
  endfunction
  logic [7:0]  ctrl_q;
  logic [15:0] bar_lo_q, bar_hi_q, zero_q, span_q, code_q, code_active_q;
  logic [4:0]  bp_idx_q;
  logic [15:0] bp_cur_q;
  logic [15:0] bp_val_q;
  logic        menu_open_q;
  logic        fail_q;
  idc_tare_e   tare_q;
  logic [TW-1:0] hold_q;
  logic        tare_on_q;
  logic signed [31:0] tare_off_q, gross, net, shown;
  logic        key_e_q;
  logic [15:0] prev_cur_q, next_cur_q;
  idc_bp_if bp_bus ();
  idc_bp_mem #(.DEPTH(BP_NUM)) u_mem (.pclk(pclk), .ce(ce), .bp(bp_bus));
  wire wr_en = psel && penable && pwrite && ce;
  wire rd_en = psel && penable && !pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= IDC_RESTORE_OFS);
  // Gross reading, linear between zero and span over 4-20 mA.
  // zero span
  always_comb begin
    gross = $signed({16'h0, zero_q}) + (($signed({16'h0, loop_current}) -
            $signed({16'h0, IDC_I_4MA})) * ($signed({16'h0, span_q}) -
            $signed({16'h0, zero_q}))) / $signed({16'h0, IDC_I_20MA - IDC_I_4MA});
  end
  always_comb begin
    net = tare_on_q ? (gross - tare_off_q) : gross;
  end
  always_comb begin
    if (key_p && ctrl_q[IDC_CTRL_PCT_BIT]) begin
      shown = clamp_pct(gross - $signed({16'h0, zero_q}),
                        $signed({16'h0, span_q}) - $signed({16'h0, zero_q}));
    end else if (key_p) begin
      shown = $signed({16'h0, loop_current});
    end else begin
      shown = net;
    end
  end
  // APB writes; software acts as the operator's digit entry.
  // digit edit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= 8'h00;
      bar_lo_q <= IDC_BAR_LO_RESET;
      bar_hi_q <= IDC_BAR_HI_RESET;
      zero_q   <= IDC_ZERO_RESET;
      span_q   <= IDC_SPAN_RESET;
      code_q   <= IDC_CODE_DEFAULT;
      bp_idx_q <= 5'h00;
      bp_cur_q <= 16'h0000;
      bp_val_q <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        IDC_CTRL_OFS:    ctrl_q   <= pwdata[7:0];
        IDC_BAR_LO_OFS:  bar_lo_q <= pwdata[15:0];
        IDC_BAR_HI_OFS:  bar_hi_q <= pwdata[15:0];
        IDC_ZERO_OFS:    zero_q   <= pwdata[15:0];
        IDC_SPAN_OFS:    span_q   <= pwdata[15:0];
        IDC_CODE_OFS:    code_q   <= pwdata[15:0];
        IDC_BP_IDX_OFS:  bp_idx_q <= pwdata[4:0];
        IDC_BP_CUR_OFS:  bp_cur_q <= pwdata[15:0];
        IDC_BP_VAL_OFS:  bp_val_q <= pwdata[15:0];
        IDC_RESTORE_OFS: begin
          if (pwdata[31:16] == IDC_CONFIRM_WORD && pwdata[0]) begin
            ctrl_q   <= 8'h00;
            bar_lo_q <= IDC_BAR_LO_RESET;
            bar_hi_q <= IDC_BAR_HI_RESET;
            zero_q   <= IDC_ZERO_RESET;
            span_q   <= IDC_SPAN_RESET;
            code_q   <= IDC_CODE_DEFAULT;
          end
        end
        default: ;
      endcase
    end
  end
  // Neighbour currents for the break-point check, read from the table.
  // break points
  logic [1:0] scan_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_q     <= 2'd0;
      prev_cur_q <= 16'h0000;
      next_cur_q <= 16'hffff;
    end else if (ce) begin
      scan_q <= scan_q + 2'd1;
      if (scan_q == 2'd1) prev_cur_q <= (bp_idx_q == 5'd0) ? 16'h0000 : bp_bus.rdata[31:16];
      if (scan_q == 2'd3) next_cur_q <= (32'(bp_idx_q) >= BP_NUM - 1) ? 16'hffff
                                        : bp_bus.rdata[31:16];
    end
  end
  assign bp_bus.raddr = (scan_q[1] == 1'b0) ? (bp_idx_q - 5'd1) : (bp_idx_q + 5'd1);
  wire bp_ok = (bp_cur_q >= IDC_I_MIN) && (bp_cur_q <= IDC_I_MAX) &&
               (bp_cur_q > prev_cur_q) && (bp_cur_q < next_cur_q) &&
               (32'(bp_idx_q) < BP_NUM);
  wire bp_commit = wr_en && (paddr == IDC_BP_VAL_OFS);
  wire lin_reset = wr_en && (paddr == IDC_RESTORE_OFS) &&
                   (pwdata[31:16] == IDC_CONFIRM_WORD) && pwdata[1];
  assign bp_bus.we    = (bp_commit && bp_ok) || lin_reset;
  assign bp_bus.waddr = lin_reset ? 5'd0 : bp_idx_q;
  assign bp_bus.wdata = lin_reset ? {IDC_I_4MA, 16'h0000} : {bp_cur_q, pwdata[15:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
    end else if (bp_commit) begin
      fail_q <= !bp_ok;
    end else if (wr_en && paddr == IDC_STATUS_OFS) begin
      fail_q <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_open_q   <= 1'b0;
      code_active_q <= IDC_CODE_DEFAULT;
    end else if (ce) begin
      if (menu_request && !menu_open_q) begin
        menu_open_q <= (code_active_q == IDC_CODE_DEFAULT) || (entered_code == code_active_q);
      end else if (!menu_request && menu_open_q) begin
        menu_open_q   <= 1'b0;
        code_active_q <= code_q;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tare_q     <= IDC_TARE_IDLE;
      hold_q     <= '0;
      tare_on_q  <= 1'b0;
      tare_off_q <= 32'sd0;
      key_e_q    <= 1'b0;
    end else if (ce) begin
      key_e_q <= key_e;
      case (tare_q)
        IDC_TARE_IDLE: begin
          hold_q <= '0;
          if (key_e && !key_e_q && ctrl_q[IDC_CTRL_TARE_BIT] && !menu_open_q) tare_q <= IDC_TARE_HELD;
        end
        IDC_TARE_HELD: begin
          if (!key_e) begin
            tare_q <= IDC_TARE_IDLE;
            if (tare_on_q) tare_on_q <= 1'b0;
          end else if (32'(hold_q) >= TARE_CYCLES) begin
            tare_on_q  <= 1'b1;
            tare_off_q <= gross;
            tare_q     <= IDC_TARE_WAIT;
          end else begin
            hold_q <= hold_q + TW'(1);
          end
        end
        IDC_TARE_WAIT: if (!key_e) tare_q <= IDC_TARE_IDLE;
        default: tare_q <= IDC_TARE_IDLE;
      endcase
      if (!ctrl_q[IDC_CTRL_TARE_BIT]) tare_on_q <= 1'b0;
    end
  end
  // Display outputs.
  // range patterns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_value       <= 18'h0;
      dp_flash         <= 1'b0;
      loop_low_message <= 1'b0;
      disp_mode_ma     <= 1'b0;
      disp_mode_pct    <= 1'b0;
      tare_annunciator <= 1'b0;
      fail_message     <= 1'b0;
      menu_granted     <= 1'b0;
    end else if (ce) begin
      loop_low_message <= loop_current < IDC_I_LOOPLOW;
      disp_mode_ma     <= key_p && !ctrl_q[IDC_CTRL_PCT_BIT];
      disp_mode_pct    <= key_p && ctrl_q[IDC_CTRL_PCT_BIT];
      tare_annunciator <= tare_on_q;
      fail_message     <= fail_q;
      menu_granted     <= menu_open_q;
      if (shown > IDC_DISP_MAX) begin
        disp_value <= IDC_DISP_MAX[17:0];
        dp_flash   <= 1'b1;
      end else if (shown < IDC_DISP_MIN) begin
        disp_value <= IDC_DISP_MIN[17:0];
        dp_flash   <= 1'b1;
      end else begin
        disp_value <= shown[17:0];
        dp_flash   <= 1'b0;
      end
    end
  end
  // Bargraph from the tared value.
  // bar segments
  logic signed [31:0] lo_s, hi_s, pos;
  logic [30:0] bar_d;
  always_comb begin
    lo_s  = $signed({16'h0, bar_lo_q});
    hi_s  = $signed({16'h0, bar_hi_q});
    pos   = (hi_s > lo_s) ? ((net - lo_s) * 32'sd31) / (hi_s - lo_s) : 32'sd0;
    if (pos < 0) pos = 0;
    if (pos > 31) pos = 31;
    bar_d = 31'h0;
    for (int i = 0; i < IDC_BAR_SEGS; i++) begin
      case (ctrl_q[2:0])
        IDC_JUST_LEFT, IDC_JUST_ALARM: bar_d[i] = (i < pos);
        IDC_JUST_CENTRE: bar_d[i] = (pos >= 15) ? (i >= 15 && i <= pos) : (i >= pos && i <= 15);
        IDC_JUST_RIGHT:  bar_d[i] = (i >= pos);
        default:         bar_d[i] = 1'b0;
      endcase
    end
    if (ctrl_q[2:0] == IDC_JUST_ALARM && !ctrl_q[IDC_CTRL_ALM_BIT]) bar_d = 31'h0;
    if (hi_s <= lo_s && ctrl_q[2:0] != IDC_JUST_OFF) bar_d = 31'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bar_segments <= 31'h0;
      bar_flash    <= 1'b0;
      arrow_low    <= 1'b0;
      arrow_high   <= 1'b0;
    end else if (ce) begin
      bar_segments <= bar_d;
      bar_flash    <= (hi_s <= lo_s) && ctrl_q[2:0] != IDC_JUST_OFF;
      arrow_low    <= (net < lo_s) && ctrl_q[2:0] != IDC_JUST_OFF;
      arrow_high   <= (net > hi_s) && ctrl_q[2:0] != IDC_JUST_OFF;
    end
  end
  // APB read and answer, one wait-free access phase.
  // menu unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en || (psel && !penable && !pwrite)) begin
        case (paddr)
          IDC_CTRL_OFS:    prdata <= {24'h0, ctrl_q};
          IDC_BAR_LO_OFS:  prdata <= {16'h0, bar_lo_q};
          IDC_BAR_HI_OFS:  prdata <= {16'h0, bar_hi_q};
          IDC_ZERO_OFS:    prdata <= {16'h0, zero_q};
          IDC_SPAN_OFS:    prdata <= {16'h0, span_q};
          IDC_CODE_OFS:    prdata <= {16'h0, code_q};
          IDC_READING_OFS: prdata <= gross;
          IDC_STATUS_OFS:  prdata <= {27'h0, menu_open_q, fail_q, tare_on_q,
                                      loop_low_message, dp_flash};
          IDC_DISP_OFS:    prdata <= {14'h0, disp_value};
          IDC_BAR_OFS:     prdata <= {1'b0, bar_segments};
          IDC_BP_IDX_OFS:  prdata <= {27'h0, bp_idx_q};
          IDC_BP_CUR_OFS:  prdata <= {16'h0, bp_cur_q};
          default:         prdata <= 32'h0;
        endcase
      end
    end
  end
  a_tare_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ce && $rose(tare_on_q) |=> tare_annunciator) else $error("tare lamp late");
  a_bar_inverted: assert property (@(posedge pclk) disable iff (!presetn)
    ce && bar_hi_q <= bar_lo_q && ctrl_q[2:0] != IDC_JUST_OFF && $stable(ctrl_q) |=> bar_flash)
    else $error("inverted bar not flagged");
  a_bad_bp_fail: assert property (@(posedge pclk) disable iff (!presetn)
    bp_commit && !bp_ok |=> fail_q) else $error("bad break-point accepted");
  a_loop_low: assert property (@(posedge pclk) disable iff (!presetn)
    ce && loop_current < IDC_I_LOOPLOW |=> loop_low_message) else $error("loop low missed");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("apb not ready");
  a_code_default: assert property (@(posedge pclk) disable iff (!presetn)
    ce && menu_request && !menu_open_q && code_active_q == IDC_CODE_DEFAULT |=> menu_open_q)
    else $error("default code refused");
  a_code_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    ce && menu_request && !menu_open_q && code_active_q != IDC_CODE_DEFAULT &&
    entered_code != code_active_q |=> !menu_open_q) else $error("wrong code let in");
  a_range_flash: assert property (@(posedge pclk) disable iff (!presetn)
    ce && shown > IDC_DISP_MAX |=> dp_flash && disp_value == IDC_DISP_MAX[17:0])
    else $error("over-range not shown");
  a_arrow_high: assert property (@(posedge pclk) disable iff (!presetn)
    ce && net > $signed({16'h0, bar_hi_q}) && ctrl_q[2:0] != 3'b100 |=> arrow_high)
    else $error("high arrow missing");
endmodule : idc_top
`default_nettype wire

// ### design/idc_pkg.sv
package idc_pkg;
  // APB register byte offsets.
  localparam logic [7:0] IDC_CTRL_OFS     = 8'h00;
  localparam logic [7:0] IDC_BAR_LO_OFS   = 8'h04;
  localparam logic [7:0] IDC_BAR_HI_OFS   = 8'h08;
  localparam logic [7:0] IDC_ZERO_OFS     = 8'h0c;
  localparam logic [7:0] IDC_SPAN_OFS     = 8'h10;
  localparam logic [7:0] IDC_CODE_OFS     = 8'h14;
  localparam logic [7:0] IDC_READING_OFS  = 8'h18;
  localparam logic [7:0] IDC_STATUS_OFS   = 8'h1c;
  localparam logic [7:0] IDC_DISP_OFS     = 8'h20;
  localparam logic [7:0] IDC_BAR_OFS      = 8'h24;
  localparam logic [7:0] IDC_BP_IDX_OFS   = 8'h28;
  localparam logic [7:0] IDC_BP_CUR_OFS   = 8'h2c;
  localparam logic [7:0] IDC_BP_VAL_OFS   = 8'h30;
  localparam logic [7:0] IDC_RESTORE_OFS  = 8'h34;
  // Control field positions.
  localparam int IDC_CTRL_JUST_LSB = 0;
  localparam int IDC_CTRL_PCT_BIT  = 3;
  localparam int IDC_CTRL_TARE_BIT = 4;
  localparam int IDC_CTRL_LIN_BIT  = 5;
  localparam int IDC_CTRL_ALM_BIT  = 6;
  // Values after reset, and the word that confirms a restore.
  localparam logic [15:0] IDC_CODE_DEFAULT = 16'h0000;
  localparam logic [15:0] IDC_ZERO_RESET   = 16'h0000;
  localparam logic [15:0] IDC_SPAN_RESET   = 16'h2710;
  localparam logic [15:0] IDC_BAR_LO_RESET = 16'h0000;
  localparam logic [15:0] IDC_BAR_HI_RESET = 16'h2710;
  localparam logic [15:0] IDC_CONFIRM_WORD = 16'h5c7e;
  // Display range and pattern limits, signed display counts.
  localparam logic signed [31:0] IDC_DISP_MAX = 32'sh0001869f;
  localparam logic signed [31:0] IDC_DISP_MIN = -32'sh0001869f;
  // Currents in microamps.
  localparam logic [15:0] IDC_I_4MA     = 16'h0fa0;
  localparam logic [15:0] IDC_I_20MA    = 16'h4e20;
  localparam logic [15:0] IDC_I_MIN     = 16'h0ed8;
  localparam logic [15:0] IDC_I_MAX     = 16'h5208;
  localparam logic [15:0] IDC_I_LOOPLOW = 16'h0708;
  // Tare hold threshold, break-point count and bar segment count.
  localparam int IDC_TARE_HOLD_MS = 3000;
  localparam int IDC_CLK_MHZ      = 125;
  localparam int IDC_TARE_CYCLES  = IDC_TARE_HOLD_MS * 1000 * IDC_CLK_MHZ;
  localparam int IDC_BP_NUM       = 17;
  localparam int IDC_BAR_SEGS     = 31;

  typedef enum logic [2:0] {
    IDC_JUST_LEFT   = 3'b000,
    IDC_JUST_CENTRE = 3'b001,
    IDC_JUST_RIGHT  = 3'b010,
    IDC_JUST_ALARM  = 3'b011,
    IDC_JUST_OFF    = 3'b100
  } idc_just_e;

  typedef enum logic [1:0] {
    IDC_TARE_IDLE = 2'b00,
    IDC_TARE_HELD = 2'b01,
    IDC_TARE_WAIT = 2'b10
  } idc_tare_e;
endpackage : idc_pkg

// ### design/idc_bp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface idc_bp_if;
  logic        we;
  logic [4:0]  waddr;
  logic [31:0] wdata;
  logic [4:0]  raddr;
  logic [31:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : idc_bp_if
`default_nettype wire

// ### design/idc_bp_mem.sv
`timescale 1ns/10ps
`default_nettype none
// Break-point table, current in upper half and display value in lower half.
module idc_bp_mem #(
  parameter int DEPTH = 17
) (
  // Clock.
  input wire logic pclk,
  input wire logic ce,
  // Table port.
  idc_bp_if.mem    bp
);
  logic [31:0] mem_q [DEPTH];

  always_ff @(posedge pclk) begin
    if (ce && bp.we && (32'(bp.waddr) < DEPTH)) begin
      mem_q[bp.waddr] <= bp.wdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (ce) begin
      bp.rdata <= (32'(bp.raddr) < DEPTH) ? mem_q[bp.raddr] : 32'h0;
    end
  end
endmodule : idc_bp_mem
`default_nettype wire

// ### tb/idc_operator.sv
`timescale 1ns/10ps
`default_nettype none
// Front-panel operator and loop source; keys change just after a clock edge.
module idc_operator (
  // Clock.
  input  wire logic        pclk,
  // Keys, code entry and loop current.
  output var  logic        key_p,
  output var  logic        key_e,
  output var  logic        menu_request,
  output var  logic [15:0] entered_code,
  output var  logic [15:0] loop_current
);
  initial begin
    key_p = 1'b0;
    key_e = 1'b0;
    menu_request = 1'b0;
    entered_code = 16'hffff;
    loop_current = 16'h2ee0;
  end

  task automatic hold_e(input int n);
    key_e <= 1'b1;
    repeat (n) @(posedge pclk);
    key_e <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_p(input logic v);
    key_p <= v;
    @(posedge pclk);
  endtask

  // code is offered before the request rises.
  task automatic ask_menu(input logic [15:0] code);
    entered_code <= code;
    @(posedge pclk);
    menu_request <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // The code lines no longer mean anything once the request is gone.
  task automatic leave_menu();
    menu_request <= 1'b0;
    entered_code <= ~entered_code;
    repeat (4) @(posedge pclk);
  endtask

  task automatic set_loop(input logic [15:0] ua);
    loop_current <= ua;
    @(posedge pclk);
  endtask
endmodule // idc_operator
`default_nettype wire

// ### tb/indicator_display_config_test.sv
`timescale 1ns/10ps
`default_nettype none
module indicator_display_config_test;
  import idc_pkg::*;
  localparam int TC = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, seed = 32'h00000062;
  logic        pready, pslverr, err, key_p, key_e, menu_request;
  logic        dm_ma, dm_pct, dpf, lowm, failm, tare, barf, arl, arh, grant;
  logic [15:0] loop_current, entered_code;
  logic [17:0] disp_value;
  logic [30:0] bar;
  int          mismatches = 0;
  int          n_tests = 0;
  int          i, d;

  always #4 pclk = ~pclk;

  idc_operator i_op (.pclk(pclk), .key_p(key_p), .key_e(key_e), .menu_request(menu_request),
    .entered_code(entered_code), .loop_current(loop_current));

  idc_top #(.TARE_CYCLES(TC)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_p(key_p), .key_e(key_e),
    .menu_request(menu_request), .loop_current(loop_current), .entered_code(entered_code),
    .disp_value(disp_value), .disp_mode_ma(dm_ma), .disp_mode_pct(dm_pct), .dp_flash(dpf),
    .loop_low_message(lowm), .fail_message(failm), .tare_annunciator(tare),
    .bar_segments(bar), .bar_flash(barf), .arrow_low(arl), .arrow_high(arh),
    .menu_granted(grant));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Display count for a loop current with zero 0 and span 10000.
  function automatic int exp_disp(input int ua);
    return (ua - 4000) * 10000 / 16000;
  endfunction

  function automatic logic pick(input int k);
    case (k)
      0: return dm_ma;
      1: return dm_pct;
      2: return tare;
      3: return lowm;
      4: return failm;
      5: return grant;
      6: return barf;
      7: return arl;
      8: return arh;
      default: return dpf;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Waits, bounded, for a display flag to reach a level, then compares it.
  task automatic wait_on(input int k, input logic v);
    for (int j = 0; j < 200 && pick(k) !== v; j++) @(posedge pclk);
    chk({31'h0, pick(k)}, {31'h0, v});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int j;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (j == 50) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    apb(1'b1, a, dv);
  endtask

  task automatic bars(input int lo, input int hi);
    wr(IDC_BAR_LO_OFS, lo);
    wr(IDC_BAR_HI_OFS, hi);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IDC_ZERO_OFS, 32'h0);
    chk(rd[15:0], IDC_ZERO_RESET);
    apb(1'b0, IDC_SPAN_OFS, 32'h0);
    chk(rd[15:0], IDC_SPAN_RESET);
    apb(1'b0, IDC_BAR_HI_OFS, 32'h0);
    chk(rd[15:0], IDC_BAR_HI_RESET);
    apb(1'b0, IDC_CODE_OFS, 32'h0);
    chk(rd[15:0], IDC_CODE_DEFAULT);
    apb(1'b0, 8'h3c, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 8'h02, 32'h0);
    chk(err, 1'b1);
    for (i = 0; i < 6; i++) begin
      d = rnd() % 10000;
      wr(IDC_BAR_LO_OFS, d);
      apb(1'b0, IDC_BAR_LO_OFS, 32'h0);
      chk(rd[15:0], d[15:0]);
    end
    $display("test registers done");
    wr(IDC_CTRL_OFS, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = 4000 + rnd() % 16000;
      i_op.set_loop(d[15:0]);
      bars(0, exp_disp(d) - 500 > 0 ? exp_disp(d) - 500 : 0);
      if (exp_disp(d) > 600) wait_on(8, 1'b1);
      bars(exp_disp(d) + 500, 10000);
      wait_on(7, 1'b1);
    end
    bars(6000, 6000);
    wait_on(6, 1'b1);
    chk($countones(bar), 1);
    bars(0, 10000);
    wait_on(6, 1'b0);
    i_op.set_loop(16'h4650);
    for (i = 0; i < 5; i++) begin
      wr(IDC_CTRL_OFS, i | 32'h40);
      repeat (4) @(posedge pclk);
      chk(bar == 31'h0, i == 4);
    end
    $display("test bargraph done");
    wr(IDC_CTRL_OFS, 32'h0);
    i_op.set_p(1'b1);
    wait_on(0, 1'b1);
    chk(disp_value, 32'h4650);
    i_op.set_p(1'b0);
    wr(IDC_CTRL_OFS, 32'h8);
    i_op.set_p(1'b1);
    wait_on(1, 1'b1);
    chk(disp_value, exp_disp(18000) * 1000 / 10000);
    i_op.set_p(1'b0);
    wr(IDC_CTRL_OFS, 32'h0);
    i_op.hold_e(TC + 5);
    wait_on(2, 1'b0);
    wr(IDC_CTRL_OFS, 32'h10);
    i_op.hold_e(TC / 2);
    wait_on(2, 1'b0);
    i_op.hold_e(TC + 5);
    wait_on(2, 1'b1);
    chk(disp_value, 32'h0);
    chk(bar, 32'h0);
    i_op.hold_e(3);
    wait_on(2, 1'b0);
    chk(disp_value, exp_disp(18000));
    $display("test keys done");
    // A low clock enable must hold the display state still.
    ce <= 1'b0;
    i_op.set_loop(16'h0700);
    repeat (4) @(posedge pclk);
    chk(lowm, 1'b0);
    ce <= 1'b1;
    wait_on(3, 1'b1);
    i_op.set_loop(IDC_I_4MA);
    wait_on(3, 1'b0);
    wr(IDC_SPAN_OFS, 32'hffff);
    i_op.set_loop(16'h7530);
    wait_on(9, 1'b1);
    chk(disp_value, IDC_DISP_MAX);
    wr(IDC_SPAN_OFS, IDC_SPAN_RESET);
    wait_on(9, 1'b0);
    wr(IDC_BP_IDX_OFS, 32'h3);
    wr(IDC_BP_CUR_OFS, 32'h0e00);
    wr(IDC_BP_VAL_OFS, 32'h64);
    wait_on(4, 1'b1);
    wr(IDC_STATUS_OFS, 32'h8);
    wait_on(4, 1'b0);
    wr(IDC_BP_CUR_OFS, 32'h5300);
    wr(IDC_BP_VAL_OFS, 32'h64);
    wait_on(4, 1'b1);
    wr(IDC_STATUS_OFS, 32'h8);
    $display("test loop and lineariser done");
    i_op.ask_menu(rnd());
    wait_on(5, 1'b1);
    wr(IDC_CODE_OFS, 32'h1234);
    i_op.leave_menu();
    i_op.ask_menu(16'h1111);
    chk(grant, 1'b0);
    i_op.leave_menu();
    i_op.ask_menu(16'h1234);
    wait_on(5, 1'b1);
    i_op.leave_menu();
    wr(IDC_BAR_LO_OFS, 32'h123);
    // a wrong confirm word changes nothing.
    wr(IDC_RESTORE_OFS, 32'h1);
    apb(1'b0, IDC_BAR_LO_OFS, 32'h0);
    chk(rd[15:0], 16'h0123);
    wr(IDC_RESTORE_OFS, {IDC_CONFIRM_WORD, 16'h2});
    apb(1'b0, IDC_BAR_LO_OFS, 32'h0);
    chk(rd[15:0], 16'h0123);
    wr(IDC_RESTORE_OFS, {IDC_CONFIRM_WORD, 16'h1});
    apb(1'b0, IDC_BAR_LO_OFS, 32'h0);
    chk(rd[15:0], IDC_BAR_LO_RESET);
    apb(1'b0, IDC_CODE_OFS, 32'h0);
    chk(rd[15:0], IDC_CODE_DEFAULT);
    $display("test code and restore done");
    end_of_test();
  end
endmodule // indicator_display_config_test
`default_nettype wire
